// file: src/dip_map.svh
`ifndef DIP_MAP_SVH
`define DIP_MAP_SVH
// Operation class codes from decode
`define DIP_OP_W        5
`define DIP_OP_NOP      5'h00
`define DIP_OP_MOV      5'h01
`define DIP_OP_NOT      5'h02
`define DIP_OP_SLD      5'h03
`define DIP_OP_SST      5'h04
`define DIP_OP_SAT      5'h05
`define DIP_OP_MULH     5'h06
`define DIP_OP_LOGIC    5'h07
`define DIP_OP_TST      5'h08
`define DIP_OP_ADD      5'h09
`define DIP_OP_SUB      5'h0A
`define DIP_OP_CMP      5'h0B
`define DIP_OP_SHIFT    5'h0C
`define DIP_OP_EXT      5'h0D
`define DIP_OP_UNCONDITIONAL_BRANCH 5'h0E
`define DIP_OP_BCC      5'h0F
`define DIP_OP_JUMP_RELATIVE 5'h10
`define DIP_OP_JUMP_AND_LINK 5'h11
`define DIP_OP_LD       5'h12
`define DIP_OP_OTHER    5'h1F
// Register numbers
`define DIP_REG_W       5
`define DIP_ZERO_REG    5'h00
`define DIP_ELEMENT_POINTER_REG 5'h1E
// Address regions and alignment
`define DIP_REG_IRAM    2'h1
`define DIP_REG_IROM    2'h2
`define DIP_ALIGN_MASK  2'h3
// Number of load buffers and general timers
`define DIP_LDBUF_N     2
`define DIP_TIMER_N     3
`endif

// file: src/dip_pkg.sv
`include "dip_map.svh"
package dip_pkg;
    // One decoded instruction slot
    typedef struct packed {
        logic                     valid;
        logic [`DIP_OP_W-1:0]     op;
        logic [`DIP_REG_W-1:0]    dst;
        logic [`DIP_REG_W-1:0]    base;
        logic                     sets_flags;
        logic [1:0]               addr_lo;
        logic                     is_target;
        logic                     ram_data;
        logic [1:0]               region;
    } dip_slot_t;
    // Issue decision
    typedef struct packed {
        logic fuse;
        logic pair;
        logic stall;
    } dip_issue_t;
    // Spurious-break detector states
    typedef enum logic [3:0] {
        DIP_SB_IDLE = 4'b0001,
        DIP_SB_ONE  = 4'b0010,
        DIP_SB_TWO  = 4'b0100,
        DIP_SB_NOP  = 4'b1000
    } dip_sb_t;
endpackage : dip_pkg

// file: src/dip_break_ctl.sv
`timescale 1ns/1ps
`include "dip_map.svh"
module dip_break_ctl
    import dip_pkg::*;
(
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    // Break state and settings
    input  wire logic                     halted,
    input  wire logic                     periph_break_en,
    // Peripheral events
    input  wire logic                     irq_raw,
    input  wire logic                     irq_taken,
    // Outputs
    output logic                          irq_pend_ff,
    output logic                          irq_req_ff,
    output logic                          wdt_run_ff,
    output logic [`DIP_TIMER_N-1:0]       tmr_run_ff
);
    // Latch requests; set wins over take
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pend_ff <= 1'b0;
        end else if (irq_raw) begin
            irq_pend_ff <= 1'b1;
        end else if (irq_taken) begin
            irq_pend_ff <= 1'b0;
        end
    end
    // Request to core only while running
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_req_ff <= 1'b0;
        end else begin
            irq_req_ff <= (irq_pend_ff | irq_raw) & ~halted;
        end
    end
    // Watchdog enable
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_run_ff <= 1'b0;
        end else begin
            wdt_run_ff <= ~halted;
        end
    end
    // Per-timer freeze
    genvar gi;
    generate
        for (gi = 0; gi < `DIP_TIMER_N; gi++) begin : g_tmr
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    tmr_run_ff[gi] <= 1'b0;
                end else begin
                    tmr_run_ff[gi] <= ~(halted & periph_break_en);
                end
            end
        end
    endgenerate

    property p_wdt_stop;
        @(posedge ref_clk) disable iff (!rst_n) halted |=> !wdt_run_ff;
    endproperty
    a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog ran in break");
    property p_tmr_freeze;
        @(posedge ref_clk) disable iff (!rst_n)
            (halted && periph_break_en) |=> (tmr_run_ff == '0);
    endproperty
    a_tmr_freeze: assert property (p_tmr_freeze) else $error("timer ran in break");
    property p_irq_held;
        @(posedge ref_clk) disable iff (!rst_n)
            (irq_raw && halted) |=> (irq_pend_ff && !irq_req_ff);
    endproperty
    a_irq_held: assert property (p_irq_held) else $error("irq not held");
endmodule : dip_break_ctl

// file: src/dip_pair_ctl.sv
`timescale 1ns/1ps
`include "dip_map.svh"
// Behaviour
// - A move followed by an arithmetic-class op with the same nonzero destination is fused.
// - Fusion happens only when the move comes first.
// - An unconditional branch pairs after no-op, move, not, short load/store or ALU ops.
// - A conditional branch pairs only after a flag-preserving instruction.
// - A short load pairs after no-op, move, not or ALU ops.
// - Only a branch or short load may be the second of a pair.
// - No pairing when the first is the first after a branch to an unaligned target.
// - A short load with pending element-pointer writeback does not pair and waits.
// - A conditional branch after either of two flag writers does not pair and stalls.
// - A short load does not pair while both load buffers await writeback.
// - Hardware breakpoints on paired instructions are unreliable; an indication is given.
// - Interrupts raised during break are held pending until resume.
// - The watchdog counter stops during break.
// - The three timers freeze in break when the peripheral-break setting says so.
// - A spurious unmapped-access break is flagged for RAM-RAM data then a jump to ROM.
module dip_pair_ctl
    import dip_pkg::*;
(
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    // Decoded instruction pair
    input  dip_slot_t                     slot_a,
    input  dip_slot_t                     slot_b,
    input  wire logic                     advance,
    // Writeback state and breakpoint hit
    input  wire logic                     ptr_wrback_pend,
    input  wire logic [`DIP_LDBUF_N-1:0]  ldbuf_busy,
    input  wire logic                     hw_bp_hit,
    // Break control
    input  wire logic                     halted,
    input  wire logic                     periph_break_en,
    input  wire logic                     irq_raw,
    input  wire logic                     irq_taken,
    // Issue decision and status
    output dip_issue_t                    issue_ff,
    output logic                          bp_unsafe_ff,
    output logic                          spur_break_ff,
    output logic                          irq_pend_ff,
    output logic                          irq_req_ff,
    output logic                          wdt_run_ff,
    output logic [`DIP_TIMER_N-1:0]       tmr_run_ff
);
    // Arithmetic class usable after a fused move
    function automatic logic fusable(input logic [`DIP_OP_W-1:0] op);
        case (op)
            `DIP_OP_SAT, `DIP_OP_MULH, `DIP_OP_LOGIC, `DIP_OP_ADD,
            `DIP_OP_SUB, `DIP_OP_SHIFT: fusable = 1'b1;
            default:                    fusable = 1'b0;
        endcase
    endfunction : fusable
    // Common leaders for unconditional-branch and short-load pairs
    function automatic logic alu_lead(input logic [`DIP_OP_W-1:0] op);
        case (op)
            `DIP_OP_NOP, `DIP_OP_MOV, `DIP_OP_NOT, `DIP_OP_SAT, `DIP_OP_MULH,
            `DIP_OP_LOGIC, `DIP_OP_TST, `DIP_OP_ADD, `DIP_OP_SUB,
            `DIP_OP_CMP, `DIP_OP_SHIFT: alu_lead = 1'b1;
            default:                    alu_lead = 1'b0;
        endcase
    endfunction : alu_lead
    // Flag-preserving leaders
    function automatic logic flag_safe(input logic [`DIP_OP_W-1:0] op);
        case (op)
            `DIP_OP_NOP, `DIP_OP_MOV, `DIP_OP_SLD, `DIP_OP_SST, `DIP_OP_MULH,
            `DIP_OP_EXT: flag_safe = 1'b1;
            default:     flag_safe = 1'b0;
        endcase
    endfunction : flag_safe

    logic       both_v;
    logic       nxt_fuse;
    logic       elig;
    logic       unaligned;
    logic       ptr_hz;
    logic       flag_hz;
    logic       buf_full;
    logic       nxt_pair;
    logic       nxt_stall;
    logic       prev_flags_ff;
    dip_sb_t    sb_ff;
    dip_sb_t    nxt_sb;

    // Fusion and eligibility
    always_comb begin
        both_v   = slot_a.valid & slot_b.valid;
        nxt_fuse = both_v & (slot_a.op == `DIP_OP_MOV) & fusable(slot_b.op)
                 & (slot_a.dst == slot_b.dst) & (slot_a.dst != `DIP_ZERO_REG);
        case (slot_b.op)
            `DIP_OP_UNCONDITIONAL_BRANCH: elig = alu_lead(slot_a.op)
                | (slot_a.op == `DIP_OP_SLD) | (slot_a.op == `DIP_OP_SST);
            `DIP_OP_BCC: elig = flag_safe(slot_a.op);
            `DIP_OP_SLD: elig = alu_lead(slot_a.op);
            default:     elig = 1'b0;
        endcase
    end
    // Blocking conditions, all in the same cycle
    always_comb begin
        unaligned = slot_a.is_target & ((slot_a.addr_lo & `DIP_ALIGN_MASK) != 2'h0);
        ptr_hz    = (slot_b.op == `DIP_OP_SLD)
                  & (slot_b.base == `DIP_ELEMENT_POINTER_REG)
                  & (ptr_wrback_pend | (slot_a.dst == `DIP_ELEMENT_POINTER_REG));
        flag_hz   = (slot_b.op == `DIP_OP_BCC)
                  & (slot_a.sets_flags | prev_flags_ff);
        buf_full  = (slot_b.op == `DIP_OP_SLD) & (&ldbuf_busy);
        nxt_pair  = both_v & ~nxt_fuse & elig
                  & ~(unaligned | ptr_hz | flag_hz | buf_full);
        nxt_stall = both_v & (ptr_hz | flag_hz);
    end
    // Flag writer history, one instruction back
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_flags_ff <= 1'b0;
        end else if (advance) begin
            prev_flags_ff <= slot_a.valid & slot_a.sets_flags;
        end
    end
    // Registered issue decision
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            issue_ff <= '0;
        end else begin
            issue_ff <= '{fuse: nxt_fuse, pair: nxt_pair, stall: nxt_stall};
        end
    end
    // Hardware breakpoint on a paired or fused slot is unreliable
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bp_unsafe_ff <= 1'b0;
        end else begin
            bp_unsafe_ff <= hw_bp_hit & (nxt_pair | nxt_fuse);
        end
    end
    // Spurious break detector over the retiring stream
    always_comb begin
        nxt_sb = sb_ff;
        case (sb_ff)
            DIP_SB_IDLE: if (slot_a.valid & slot_a.ram_data) nxt_sb = DIP_SB_ONE;
            DIP_SB_ONE:  nxt_sb = (slot_a.valid & slot_a.ram_data) ? DIP_SB_TWO : DIP_SB_IDLE;
            DIP_SB_TWO: begin
                if (slot_a.valid & slot_a.ram_data) begin
                    nxt_sb = DIP_SB_TWO; // A third access keeps the last two back to back
                end else if (slot_a.op == `DIP_OP_NOP) begin
                    nxt_sb = DIP_SB_NOP;
                end else begin
                    nxt_sb = DIP_SB_IDLE;
                end
            end
            DIP_SB_NOP:  nxt_sb = (slot_a.valid & slot_a.ram_data) ? DIP_SB_ONE : DIP_SB_IDLE;
            default:     nxt_sb = DIP_SB_IDLE;
        endcase
        if (slot_a.region != `DIP_REG_IRAM) begin
            nxt_sb = DIP_SB_IDLE; // Only code running from internal RAM
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sb_ff <= DIP_SB_IDLE;
        end else if (advance) begin
            sb_ff <= nxt_sb;
        end
    end
    // Flag the jump to ROM directly or after one no-op
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            spur_break_ff <= 1'b0;
        end else begin
            spur_break_ff <= advance & ((sb_ff == DIP_SB_TWO) | (sb_ff == DIP_SB_NOP))
                & ((slot_a.op == `DIP_OP_JUMP_RELATIVE) | (slot_a.op == `DIP_OP_JUMP_AND_LINK))
                & slot_b.valid & (slot_b.region == `DIP_REG_IROM);
        end
    end
    // Break-time peripheral control
    dip_break_ctl u_brk (
        .ref_clk         (ref_clk),
        .rst_n           (rst_n),
        .halted          (halted),
        .periph_break_en (periph_break_en),
        .irq_raw         (irq_raw),
        .irq_taken       (irq_taken),
        .irq_pend_ff     (irq_pend_ff),
        .irq_req_ff      (irq_req_ff),
        .wdt_run_ff      (wdt_run_ff),
        .tmr_run_ff      (tmr_run_ff)
    );

    sequence s_flag_branch;
        both_v && slot_b.op == `DIP_OP_BCC && slot_a.sets_flags;
    endsequence
    property p_flag_hz;
        @(posedge ref_clk) disable iff (!rst_n) s_flag_branch |=> issue_ff.stall && !issue_ff.pair;
    endproperty
    a_flag_hz: assert property (p_flag_hz) else $error("branch paired on flag hazard");
    property p_no_fuse_rev;
        @(posedge ref_clk) disable iff (!rst_n) (slot_a.op != `DIP_OP_MOV) |=> !issue_ff.fuse;
    endproperty
    a_no_fuse_rev: assert property (p_no_fuse_rev) else $error("fused without move first");
    property p_zero_fuse;
        @(posedge ref_clk) disable iff (!rst_n) (slot_a.dst == `DIP_ZERO_REG) |=> !issue_ff.fuse;
    endproperty
    a_zero_fuse: assert property (p_zero_fuse) else $error("fused on zero register");
    property p_second_kind;
        @(posedge ref_clk) disable iff (!rst_n)
            !(slot_b.op inside {`DIP_OP_UNCONDITIONAL_BRANCH, `DIP_OP_BCC, `DIP_OP_SLD})
            |=> !issue_ff.pair;
    endproperty
    a_second_kind: assert property (p_second_kind) else $error("illegal second");
    property p_unaligned;
        @(posedge ref_clk) disable iff (!rst_n) unaligned |=> !issue_ff.pair;
    endproperty
    a_unaligned: assert property (p_unaligned) else $error("paired unaligned");
    property p_ptr_hz;
        @(posedge ref_clk) disable iff (!rst_n)
            (both_v && ptr_hz) |=> issue_ff.stall && !issue_ff.pair;
    endproperty
    a_ptr_hz: assert property (p_ptr_hz) else $error("load paired on pointer hazard");
    property p_buf;
        @(posedge ref_clk) disable iff (!rst_n)
            (slot_b.op == `DIP_OP_SLD && &ldbuf_busy) |=> !issue_ff.pair;
    endproperty
    a_buf: assert property (p_buf) else $error("load paired with full buffers");
    property p_grant;
        @(posedge ref_clk) disable iff (!rst_n)
            (both_v && slot_a.op == `DIP_OP_NOP && !slot_a.is_target
             && slot_b.op == `DIP_OP_UNCONDITIONAL_BRANCH) |=> issue_ff.pair;
    endproperty
    a_grant: assert property (p_grant) else $error("eligible pair refused");
endmodule : dip_pair_ctl

// file: verification/dip_fetch_model.sv
`timescale 1ns/1ps
`include "dip_map.svh"
module dip_fetch_model
    import dip_pkg::*;
(
    // Clock
    input  wire logic ref_clk,
    // Decoded pair towards the pairing control
    output dip_slot_t slot_a,
    output dip_slot_t slot_b,
    output logic      advance
);
    // Decode marks every flag writer, so a flag-preserving class never carries the mark
    function automatic logic wr_flags(input logic [`DIP_OP_W-1:0] op);
        case (op)
            `DIP_OP_NOT, `DIP_OP_SAT, `DIP_OP_LOGIC, `DIP_OP_TST, `DIP_OP_ADD, `DIP_OP_SUB,
            `DIP_OP_CMP, `DIP_OP_SHIFT: wr_flags = 1'b1;
            default: wr_flags = 1'b0;
        endcase
    endfunction : wr_flags

    // Nothing is offered before the first request
    initial begin
        slot_a  = '0;
        slot_b  = '0;
        advance = 1'b0;
    end

    // Short loads and stores in the second slot always address through the element pointer
    task automatic put(input dip_slot_t a, input dip_slot_t b, input logic adv);
        a.sets_flags = wr_flags(a.op);
        b.sets_flags = wr_flags(b.op);
        if (b.op == `DIP_OP_SLD || b.op == `DIP_OP_SST) begin
            b.base = `DIP_ELEMENT_POINTER_REG;
        end
        slot_a  = a;
        slot_b  = b;
        advance = adv;
    endtask : put
endmodule : dip_fetch_model

// file: verification/dual_issue_pairing_control_test.sv
`timescale 1ns/1ps
`include "dip_map.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module dual_issue_pairing_control_test
    import dip_pkg::*;
;
    logic       ref_clk, rst_n, ptr_wrback_pend, hw_bp_hit, halted, periph_break_en;
    logic       irq_raw, irq_taken, advance, bp_unsafe_ff, spur_break_ff;
    logic       irq_pend_ff, irq_req_ff, wdt_run_ff;
    logic [1:0] ldbuf_busy;
    logic [2:0] tmr_run_ff;
    dip_slot_t  slot_a, slot_b;
    dip_issue_t issue_ff;
    int         mismatches, n_compared, cycles;

    dip_fetch_model fe (.ref_clk(ref_clk), .slot_a(slot_a), .slot_b(slot_b), .advance(advance));
    dip_pair_ctl uut (.ref_clk(ref_clk), .rst_n(rst_n), .slot_a(slot_a), .slot_b(slot_b),
        .advance(advance), .ptr_wrback_pend(ptr_wrback_pend), .ldbuf_busy(ldbuf_busy),
        .hw_bp_hit(hw_bp_hit), .halted(halted), .periph_break_en(periph_break_en),
        .irq_raw(irq_raw), .irq_taken(irq_taken), .issue_ff(issue_ff),
        .bp_unsafe_ff(bp_unsafe_ff), .spur_break_ff(spur_break_ff), .irq_pend_ff(irq_pend_ff),
        .irq_req_ff(irq_req_ff), .wdt_run_ff(wdt_run_ff), .tmr_run_ff(tmr_run_ff));

    // Clock at 50 MHz
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // A hang counts as a mismatch and still reaches the report
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // Plain slot fetched from internal RAM, no data access
    function automatic dip_slot_t mk(input logic [4:0] op, input logic [4:0] dst);
        mk        = '0;
        mk.valid  = 1'b1;
        mk.op     = op;
        mk.dst    = dst;
        mk.region = `DIP_REG_IRAM;
    endfunction : mk

    // Expected {fuse, pair} for a hazard-free pair
    function automatic logic [1:0] exp_iss(input logic [4:0] a, b, da, db);
        logic fuse, ok;
        fuse = (a == `DIP_OP_MOV) && (da == db) && (da != `DIP_ZERO_REG) && (b inside
            {`DIP_OP_SAT, `DIP_OP_MULH, `DIP_OP_LOGIC, `DIP_OP_ADD, `DIP_OP_SUB, `DIP_OP_SHIFT});
        case (b)
            `DIP_OP_UNCONDITIONAL_BRANCH: ok = a inside {`DIP_OP_NOP, `DIP_OP_MOV, `DIP_OP_NOT,
                `DIP_OP_SLD, `DIP_OP_SST, `DIP_OP_SAT, `DIP_OP_MULH, `DIP_OP_LOGIC, `DIP_OP_TST,
                `DIP_OP_ADD, `DIP_OP_SUB, `DIP_OP_CMP, `DIP_OP_SHIFT};
            `DIP_OP_BCC: ok = a inside {`DIP_OP_NOP, `DIP_OP_MOV, `DIP_OP_SLD, `DIP_OP_SST,
                `DIP_OP_MULH, `DIP_OP_EXT};
            `DIP_OP_SLD: ok = a inside {`DIP_OP_NOP, `DIP_OP_MOV, `DIP_OP_NOT, `DIP_OP_SAT,
                `DIP_OP_MULH, `DIP_OP_LOGIC, `DIP_OP_TST, `DIP_OP_ADD, `DIP_OP_SUB,
                `DIP_OP_CMP, `DIP_OP_SHIFT};
            default: ok = 1'b0;
        endcase
        return {fuse, ok && !fuse};
    endfunction : exp_iss

    // Offer a pair just after an edge; the decision is settled one edge later
    task automatic step(input dip_slot_t a, input dip_slot_t b, input logic adv);
        fe.put(a, b, adv);
        @(posedge ref_clk);
        #1;
    endtask : step

    // A retired no-op first, so no flag writer lingers in the history
    task automatic try(input dip_slot_t a, input dip_slot_t b, input logic [1:0] ex);
        step(mk(`DIP_OP_NOP, 5'h01), mk(`DIP_OP_OTHER, 5'h02), 1'b1);
        step(a, b, 1'b1);
        `CHK("fuse and pair", ex, {issue_ff.fuse, issue_ff.pair})
    endtask : try

    // Every class against every class; same destination exposes fusion both ways round
    task automatic t_table;
        logic [4:0] fa, fb;
        for (int i = 0; i < 20; i++) begin
            fa = (i == 19) ? `DIP_OP_OTHER : 5'(i);
            for (int j = 0; j < 20; j++) begin
                fb = (j == 19) ? `DIP_OP_OTHER : 5'(j);
                try(mk(fa, 5'h03), mk(fb, 5'h03), exp_iss(fa, fb, 5'h03, 5'h03));
            end
        end
        try(mk(`DIP_OP_MOV, 5'h00), mk(`DIP_OP_ADD, 5'h00), 2'b00);
        try(mk(`DIP_OP_MOV, 5'h03), mk(`DIP_OP_ADD, 5'h04), 2'b00);
        try(mk(`DIP_OP_ADD, 5'h03), mk(`DIP_OP_MOV, 5'h03), 2'b00);
    endtask : t_table

    // Each blocker alone, against a pair that pairs when unblocked, except the compare-then-branch flag case
    task automatic t_block;
        dip_slot_t a;
        a         = mk(`DIP_OP_MOV, 5'h01);
        a.is_target = 1'b1;
        a.addr_lo = 2'h2;
        try(a, mk(`DIP_OP_UNCONDITIONAL_BRANCH, 5'h02), 2'b00);
        a.addr_lo = 2'h0;
        try(a, mk(`DIP_OP_UNCONDITIONAL_BRANCH, 5'h02), 2'b01);
        ptr_wrback_pend = 1'b1;
        try(mk(`DIP_OP_MOV, 5'h01), mk(`DIP_OP_SLD, 5'h02), 2'b00);
        ptr_wrback_pend = 1'b0;
        try(mk(`DIP_OP_MOV, `DIP_ELEMENT_POINTER_REG), mk(`DIP_OP_SLD, 5'h02), 2'b00);
        `CHK("pointer stall", 1'b1, issue_ff.stall)
        ldbuf_busy = 2'b11;
        try(mk(`DIP_OP_MOV, 5'h01), mk(`DIP_OP_SLD, 5'h02), 2'b00);
        ldbuf_busy = 2'b10;
        try(mk(`DIP_OP_MOV, 5'h01), mk(`DIP_OP_SLD, 5'h02), 2'b01);
        ldbuf_busy = 2'b00;
        try(mk(`DIP_OP_CMP, 5'h01), mk(`DIP_OP_BCC, 5'h02), 2'b00);
        `CHK("stall", 1'b1, issue_ff.stall)
        step(mk(`DIP_OP_CMP, 5'h01), mk(`DIP_OP_OTHER, 5'h02), 1'b1);
        step(mk(`DIP_OP_NOP, 5'h01), mk(`DIP_OP_BCC, 5'h02), 1'b1);
        `CHK("pair after older flag writer", 1'b0, issue_ff.pair)
        // A pair that does not retire leaves the flag history alone
        step(mk(`DIP_OP_CMP, 5'h01), mk(`DIP_OP_OTHER, 5'h02), 1'b1);
        step(mk(`DIP_OP_NOP, 5'h01), mk(`DIP_OP_OTHER, 5'h02), 1'b0);
        step(mk(`DIP_OP_NOP, 5'h01), mk(`DIP_OP_BCC, 5'h02), 1'b1);
        `CHK("flag history held", 2'b10, {issue_ff.stall, issue_ff.pair})
        hw_bp_hit = 1'b1;
        try(mk(`DIP_OP_MOV, 5'h01), mk(`DIP_OP_UNCONDITIONAL_BRANCH, 5'h02), 2'b01);
        `CHK("breakpoint unsafe", 1'b1, bp_unsafe_ff)
        try(mk(`DIP_OP_ADD, 5'h01), mk(`DIP_OP_ADD, 5'h02), 2'b00);
        `CHK("breakpoint safe", 1'b0, bp_unsafe_ff)
        hw_bp_hit = 1'b0;
    endtask : t_block

    // Interrupt raised in break waits; watchdog stops; timers follow the setting
    task automatic t_break;
        halted          = 1'b1;
        irq_raw         = 1'b1;
        periph_break_en = 1'b1;
        @(posedge ref_clk);
        #1;
        irq_raw = 1'b0;
        `CHK("pending", 2'b10, {irq_pend_ff, irq_req_ff})
        `CHK("watchdog in break", 1'b0, wdt_run_ff)
        `CHK("timers frozen", 3'b000, tmr_run_ff)
        periph_break_en = 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK("timers running", 3'b111, tmr_run_ff)
        halted = 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK("request after resume", 2'b11, {irq_pend_ff, irq_req_ff})
        `CHK("watchdog running", 1'b1, wdt_run_ff)
        irq_taken = 1'b1;
        @(posedge ref_clk);
        #1;
        irq_taken = 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK("pending cleared", 2'b00, {irq_pend_ff, irq_req_ff})
    endtask : t_break

    // Data accesses to internal RAM, optional no-op, then a jump whose target is ROM
    task automatic t_spur(input logic [4:0] jop, input int n_acc, input logic gap,
                          input logic ex);
        dip_slot_t acc, tgt;
        acc          = mk(`DIP_OP_LD, 5'h01);
        acc.ram_data = 1'b1;
        tgt          = mk(`DIP_OP_OTHER, 5'h02);
        tgt.region   = `DIP_REG_IROM;
        repeat (2) step(mk(`DIP_OP_NOP, 5'h01), mk(`DIP_OP_OTHER, 5'h02), 1'b1);
        repeat (n_acc) step(acc, mk(`DIP_OP_OTHER, 5'h02), 1'b1);
        if (gap) begin
            step(mk(`DIP_OP_NOP, 5'h01), mk(`DIP_OP_OTHER, 5'h02), 1'b1);
        end
        step(mk(jop, 5'h00), tgt, 1'b1);
        `CHK("spurious break", ex, spur_break_ff)
    endtask : t_spur

    // Main sequence
    initial begin
        {rst_n, ptr_wrback_pend, hw_bp_hit, halted, periph_break_en, irq_raw, irq_taken} = '0;
        ldbuf_busy = 2'b00;
        repeat (8) @(posedge ref_clk);
        #1;
        `CHK("outputs in reset", 11'h000, {issue_ff, bp_unsafe_ff, spur_break_ff, irq_pend_ff,
            irq_req_ff, wdt_run_ff, tmr_run_ff})
        rst_n = 1'b1;
        t_table();
        t_block();
        t_break();
        t_spur(`DIP_OP_JUMP_RELATIVE, 2, 1'b0, 1'b1);
        t_spur(`DIP_OP_JUMP_AND_LINK, 2, 1'b1, 1'b1);
        t_spur(`DIP_OP_JUMP_RELATIVE, 1, 1'b0, 1'b0);
        t_spur(`DIP_OP_JUMP_RELATIVE, 3, 1'b0, 1'b1);
        conclude();
    end
endmodule : dual_issue_pairing_control_test
